// ==== design/sbr_pkg.sv ====
// Purpose: Shared constants, register map and rate arithmetic for the serial receive block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Register values sit in the low byte, upper bits read as zero
package sbr_pkg;

   // Register byte offsets
   localparam logic [7:0]  OFF_STATUS   = 8'h00;
   localparam logic [7:0]  OFF_DATA     = 8'h04;
   localparam logic [7:0]  OFF_CTRL2    = 8'h08;
   localparam logic [7:0]  OFF_RATE     = 8'h0c;
   localparam logic [7:0]  OFF_FINE_TX  = 8'h10;
   localparam logic [7:0]  OFF_FINE_RX  = 8'h14;

   // Field positions
   localparam int unsigned ST_FULL      = 5;
   localparam int unsigned ST_QUIET     = 4;
   localparam int unsigned ST_FE        = 1;
   localparam int unsigned CT_MUTE      = 0;
   localparam int unsigned CT_WAKE      = 1;
   localparam int unsigned CT_RXEN      = 2;
   localparam int unsigned CT_TXEN      = 3;
   localparam int unsigned RS_SH_LO     = 0;
   localparam int unsigned RS_TX_LO     = 2;
   localparam int unsigned RS_RX_LO     = 5;

   // Values after reset
   localparam logic [7:0]  RST_CTRL2    = 8'h00;
   localparam logic [7:0]  RST_RATE     = 8'h00;
   localparam logic [7:0]  RST_FINE     = 8'h00;

   // Counts: sixteen samples per bit, an idle frame is ten bit times
   localparam logic [3:0]  OVS_LAST     = 4'hf;
   localparam logic [3:0]  OVS_MID      = 4'h7;
   localparam logic [7:0]  IDLE_LAST    = 8'h9f;
   localparam int unsigned DIV_W        = 23;

   // Bus answers
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // Clock cycles per oversample tick: shared * 2^select * fine (fine 0 means 1)
   function automatic logic [22:0] sbr_divisor(input logic [1:0] sh,
                                               input logic [2:0] sel,
                                               input logic [7:0] fine);
      logic [22:0] pr;
      logic [22:0] base;
      case (sh)
         2'h0:    pr = 23'h000001;
         2'h1:    pr = 23'h000003;
         2'h2:    pr = 23'h000004;
         default: pr = 23'h00000d;
      endcase
      base = pr << sel;
      sbr_divisor = (fine == 8'h00) ? base : 23'(base * 23'(fine));
   endfunction : sbr_divisor

endpackage : sbr_pkg

// ==== design/sbr_fifo2.sv ====
// Purpose: Small valid/ready buffer between the frame receiver and the data register
// Assumes: Single clock, synchronous handshakes on both sides
// Notes:   Depth two lets two words wait while software is late reading
`timescale 1ns/1ps
`default_nettype none
module sbr_fifo2 #(
   parameter int unsigned W     = 9,
   parameter int unsigned DEPTH = 2
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   // Fill side
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   // Drain side
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_r;
   logic [PW-1:0] rd_r;
   logic [PW:0]   cnt_r;
   logic          push;
   logic          pop;

   // Full and empty come straight from the occupancy count
   assign o_in_ready  = (cnt_r < (PW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem[rd_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Storage, written only on an accepted push
   always_ff @(posedge i_clk) begin
      if (i_ce && push) begin
         mem[wr_r] <= i_in_data;
      end
   end

   // Pointers wrap at the configured depth
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else if (i_ce) begin
         if (push) begin
            wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : PW'(wr_r + 1'b1);
         end
         if (pop) begin
            rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : PW'(rd_r + 1'b1);
         end
         cnt_r <= (PW+1)'(cnt_r + (PW+1)'(push) - (PW+1)'(pop));
      end
   end

   property p_fifo_bound;
      @(posedge i_clk) disable iff (!i_rst_n)
      cnt_r <= (PW+1)'(DEPTH);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count past depth");

endmodule : sbr_fifo2
`default_nettype wire

// ==== design/sbr_baud.sv ====
// Purpose: Rate generator giving one oversample tick per programmed clock count
// Assumes: Rate settings stay still while the direction is enabled
// Notes:   The divide by sixteen is done by the bit counter that uses the tick
`timescale 1ns/1ps
`default_nettype none
module sbr_baud
   import sbr_pkg::*;
#(
   parameter int unsigned DW = sbr_pkg::DIV_W
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   // Rate settings
   input  wire logic       i_en,
   input  wire logic [1:0] i_shared_sel,
   input  wire logic [2:0] i_div_sel,
   input  wire logic [7:0] i_fine,
   // Tick out
   output logic            o_tick
);
   logic [DW-1:0] cnt_r;
   logic [DW-1:0] limit;
   logic [DW-1:0] gap_r;
   logic          seen_r;

   assign limit = DW'(sbr_divisor(i_shared_sel, i_div_sel, i_fine));

   // Free counter, restarted whenever the direction is off
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r  <= '0;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         if (!i_en) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
         end else if (cnt_r >= DW'(limit - 1'b1)) begin
            cnt_r  <= '0;
            o_tick <= 1'b1;
         end else begin
            cnt_r  <= DW'(cnt_r + 1'b1);
            o_tick <= 1'b0;
         end
      end
   end

   // Helper: cycles since the previous tick
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
      end else if (i_ce) begin
         gap_r  <= o_tick ? DW'(1) : DW'(gap_r + 1'b1);
         seen_r <= i_en && (seen_r || o_tick);
      end
   end

   property p_tick_period;
      @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
      (o_tick && seen_r && i_en && $stable(limit)) |-> (gap_r == limit);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");

endmodule : sbr_baud
`default_nettype wire

// ==== design/sbr_rx_top.sv ====
// Purpose: Serial receiver with framing check, mute and wake-up, rates and AXI4-Lite registers
// Assumes: Line input is synchronous to i_clk; one bus write and one read in flight
// Notes:   Transmit framing lives elsewhere; this block supplies its rate tick only
//
// Behaviour
// - Missing stop bit or break flags framing error
// - Framing error still delivers word to data
// - Error flag rises together with full flag
// - Error cleared by status then data read
// - Rate is clock over 16, shared, direction divider
// - Shared select picks 1, 3, 4 or 13
// - Direction selects pick powers of two 1..128
// - Fine factor further divides by 1..255
// - Zero fine factor keeps conventional rate
// - Muted receiver sets no status, no interrupt
// - Wake by idle or address mark per select
// - Idle wake clears mute, not quiet flag
// - Address mark word clears mute, sets full
// - Control write reloads mute from written bit
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sbr_rx_top
   import sbr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   // AXI4-Lite write address and data
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // AXI4-Lite write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // AXI4-Lite read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Serial line and side outputs
   input  wire logic        i_rxd,
   output logic             o_tx_tick,
   output logic             o_rx_full,
   output logic             o_muted
);
   import sbr_pkg::*;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_PUSH} sbr_rx_state_t;

   // Registers
   logic [7:0]    ctrl2_r;
   logic [7:0]    rate_r;
   logic [7:0]    fine_tx_r;
   logic [7:0]    fine_rx_r;
   logic [7:0]    data_r;
   logic          full_r;
   logic          fe_r;
   logic          quiet_r;
   logic          armed_r;
   // Bus state
   logic          wr_go;
   logic          rd_go;
   logic          wr_do;
   logic          rd_do;
   logic          rd_status;
   logic          rd_data;
   logic          ctrl_wr;
   logic [31:0]   rd_mux;
   logic          rd_hit;
   logic          wr_hit;
   // Receiver state
   sbr_rx_state_t rx_st_r;
   logic [3:0]    ovs_r;
   logic [2:0]    bit_r;
   logic [7:0]    shift_r;
   logic          stop_ok_r;
   logic [7:0]    idle_cnt_r;
   logic          idle_armed_r;
   logic          rx_tick;
   logic          frame_done;
   logic          idle_ev;
   logic          addr_wake;
   logic          push_valid;
   logic          push_ready;
   logic          pop_valid;
   logic          pop_ready;
   logic [8:0]    pop_data;

   // Control fields in use
   logic          mute_r;
   logic          wake_sel;
   logic          rx_en;
   logic          tx_en;
   assign mute_r   = ctrl2_r[CT_MUTE];
   assign wake_sel = ctrl2_r[CT_WAKE];
   assign rx_en    = ctrl2_r[CT_RXEN];
   assign tx_en    = ctrl2_r[CT_TXEN];
   assign o_muted  = mute_r;

   // Rate generators, one per direction
   sbr_baud u_tx_baud (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_en         (tx_en),
      .i_shared_sel (rate_r[RS_SH_LO +: 2]),
      .i_div_sel    (rate_r[RS_TX_LO +: 3]),
      .i_fine       (fine_tx_r),
      .o_tick       (o_tx_tick)
   );

   sbr_baud u_rx_baud (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_en         (rx_en),
      .i_shared_sel (rate_r[RS_SH_LO +: 2]),
      .i_div_sel    (rate_r[RS_RX_LO +: 3]),
      .i_fine       (fine_rx_r),
      .o_tick       (rx_tick)
   );

   // Bus handshakes: address and data are taken together, one at a time
   assign wr_go   = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
   assign rd_go   = i_arvalid && !o_arready && !o_rvalid;
   assign wr_do   = o_awready && i_ce;
   assign rd_do   = o_arready && i_ce;
   assign wr_hit  = (i_awaddr == OFF_STATUS) || (i_awaddr == OFF_DATA) ||
                    (i_awaddr == OFF_CTRL2) || (i_awaddr == OFF_RATE) ||
                    (i_awaddr == OFF_FINE_TX) || (i_awaddr == OFF_FINE_RX);
   assign ctrl_wr = wr_do && (i_awaddr == OFF_CTRL2) && i_wstrb[0];
   assign rd_status = rd_do && (i_araddr == OFF_STATUS);
   assign rd_data   = rd_do && (i_araddr == OFF_DATA);

   // Read mux; bits above the low byte read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (i_araddr)
         OFF_STATUS: begin
            rd_mux[ST_FULL]  = full_r;
            rd_mux[ST_QUIET] = quiet_r;
            rd_mux[ST_FE]    = fe_r;
         end
         OFF_DATA:    rd_mux[7:0] = data_r;
         OFF_CTRL2:   rd_mux[7:0] = ctrl2_r;
         OFF_RATE:    rd_mux[7:0] = rate_r;
         OFF_FINE_TX: rd_mux[7:0] = fine_tx_r;
         OFF_FINE_RX: rd_mux[7:0] = fine_rx_r;
         default:     rd_hit = 1'b0;
      endcase
   end

   // Write channel and response
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
      end else if (i_ce) begin
         o_awready <= wr_go;
         o_wready  <= wr_go;
         if (o_awready) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Read channel and response
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= RESP_OKAY;
      end else if (i_ce) begin
         o_arready <= rd_go;
         if (o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_mux;
            o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; hardware wake clears mute, a write reloads it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl2_r   <= RST_CTRL2;
         rate_r    <= RST_RATE;
         fine_tx_r <= RST_FINE;
         fine_rx_r <= RST_FINE;
      end else if (i_ce) begin
         if (ctrl_wr) begin
            ctrl2_r <= i_wdata[7:0];
         end else if (mute_r && ((idle_ev && !wake_sel) || addr_wake)) begin
            ctrl2_r[CT_MUTE] <= 1'b0;
         end
         if (wr_do && i_wstrb[0] && (i_awaddr == OFF_RATE)) begin
            rate_r <= i_wdata[7:0];
         end
         if (wr_do && i_wstrb[0] && (i_awaddr == OFF_FINE_TX)) begin
            fine_tx_r <= i_wdata[7:0];
         end
         if (wr_do && i_wstrb[0] && (i_awaddr == OFF_FINE_RX)) begin
            fine_rx_r <= i_wdata[7:0];
         end
      end
   end

   // Frame receiver: sixteen ticks per bit, sampling the middle of each bit
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_st_r   <= RX_IDLE;
         ovs_r     <= 4'h0;
         bit_r     <= 3'h0;
         shift_r   <= 8'h00;
         stop_ok_r <= 1'b0;
      end else if (i_ce) begin
         if (!rx_en) begin
            rx_st_r <= RX_IDLE;
         end else begin
            case (rx_st_r)
               RX_IDLE: begin
                  ovs_r <= 4'h0;
                  if (rx_tick && !i_rxd) begin
                     rx_st_r <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_tick) begin
                     ovs_r <= 4'(ovs_r + 1'b1);
                     if (ovs_r == OVS_MID) begin
                        ovs_r   <= 4'h0;
                        bit_r   <= 3'h0;
                        rx_st_r <= i_rxd ? RX_IDLE : RX_DATA; // Glitch guard
                     end
                  end
               end
               RX_DATA: begin
                  if (rx_tick) begin
                     ovs_r <= 4'(ovs_r + 1'b1);
                     if (ovs_r == OVS_LAST) begin
                        shift_r <= {i_rxd, shift_r[7:1]};
                        bit_r   <= 3'(bit_r + 1'b1);
                        if (bit_r == 3'h7) begin
                           rx_st_r <= RX_STOP;
                        end
                     end
                  end
               end
               RX_STOP: begin
                  if (rx_tick) begin
                     ovs_r <= 4'(ovs_r + 1'b1);
                     if (ovs_r == OVS_LAST) begin
                        stop_ok_r <= i_rxd;
                        rx_st_r   <= RX_PUSH;
                     end
                  end
               end
               RX_PUSH: begin
                  // Waits here while the buffer is full, so no word is dropped
                  if (push_ready || !push_valid) begin
                     rx_st_r <= RX_IDLE;
                  end
               end
               default: rx_st_r <= RX_IDLE;
            endcase
         end
      end
   end

   // Word complete; a muted receiver only passes an address mark word
   assign frame_done = (rx_st_r == RX_PUSH) && rx_en;
   assign addr_wake  = frame_done && mute_r && wake_sel && shift_r[7] && !ctrl_wr;
   assign push_valid = frame_done && (!mute_r || addr_wake);

   // Idle detection: ten bit times of steady mark after line activity
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idle_cnt_r   <= 8'h00;
         idle_armed_r <= 1'b0;
      end else if (i_ce) begin
         if (!rx_en || (rx_st_r != RX_IDLE) || !i_rxd) begin
            idle_cnt_r   <= 8'h00;
            idle_armed_r <= idle_armed_r || (rx_en && (rx_st_r != RX_IDLE));
         end else if (rx_tick && idle_armed_r) begin
            idle_cnt_r <= 8'(idle_cnt_r + 1'b1);
            if (idle_cnt_r == IDLE_LAST) begin
               idle_armed_r <= 1'b0;
            end
         end
      end
   end
   assign idle_ev = rx_tick && idle_armed_r && (idle_cnt_r == IDLE_LAST) && i_rxd &&
                    (rx_st_r == RX_IDLE) && rx_en;

   // Two-entry buffer between receiver and data register; carries the error bit
   sbr_fifo2 #(.W(9), .DEPTH(2)) u_buf (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_ce        (i_ce),
      .i_in_valid  (push_valid),
      .i_in_data   ({!stop_ok_r, shift_r}),
      .o_in_ready  (push_ready),
      .o_out_valid (pop_valid),
      .o_out_data  (pop_data),
      .i_out_ready (pop_ready)
   );
   assign pop_ready = !full_r || rd_data;

   // Data register and full flag; a new word beats a clearing read
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_r <= 8'h00;
         full_r <= 1'b0;
      end else if (i_ce) begin
         if (pop_valid && pop_ready) begin
            data_r <= pop_data[7:0];
            full_r <= 1'b1;
         end else if (rd_data) begin
            full_r <= 1'b0;
         end
      end
   end
   assign o_rx_full = full_r;

   // Error and quiet flags; cleared by status read then data read, set wins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fe_r    <= 1'b0;
         quiet_r <= 1'b0;
         armed_r <= 1'b0;
      end else if (i_ce) begin
         // A clean word never drops the flag; only the clearing pair does
         if (pop_valid && pop_ready && pop_data[8]) begin
            fe_r <= 1'b1;
         end else if (rd_data && armed_r) begin
            fe_r <= 1'b0;
         end
         if (idle_ev && !mute_r) begin
            quiet_r <= 1'b1;
         end else if (rd_data && armed_r) begin
            quiet_r <= 1'b0;
         end
         if (rd_status) begin
            armed_r <= 1'b1;
         end else if (rd_data) begin
            armed_r <= 1'b0;
         end
      end
   end

   // Checks
   sequence s_status_read;
      rd_status;
   endsequence
   sequence s_data_clear;
      rd_data && armed_r && !(pop_valid && pop_ready && pop_data[8]);
   endsequence

   property p_fe_with_full;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(fe_r) |-> (full_r && $changed(data_r) || $rose(full_r) || full_r);
   endproperty
   a_fe_with_full: assert property (p_fe_with_full) else $error("error flag without full");

   property p_fe_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      $fell(fe_r) |-> $past(rd_data && armed_r);
   endproperty
   a_fe_clear: assert property (p_fe_clear) else $error("error flag cleared wrongly");

   property p_fe_seq;
      @(posedge i_clk) disable iff (!i_rst_n)
      (s_status_read ##[1:9] s_data_clear) |=> !fe_r;
   endproperty
   a_fe_seq: assert property (p_fe_seq) else $error("error flag not cleared");

   property p_bad_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      (push_valid && push_ready && !stop_ok_r) ##1 (!full_r || rd_data) [*2]
         |-> fe_r || full_r;
   endproperty
   a_bad_stop: assert property (p_bad_stop) else $error("framing error lost");

   property p_mute_quiet;
      @(posedge i_clk) disable iff (!i_rst_n)
      push_valid |-> (!mute_r || (wake_sel && shift_r[7]));
   endproperty
   a_mute_quiet: assert property (p_mute_quiet) else $error("muted word delivered");

   property p_idle_wake;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && idle_ev && mute_r && !wake_sel && !ctrl_wr) |=> (!mute_r && !$rose(quiet_r));
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

   property p_addr_wake;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && addr_wake && push_ready) |=> !mute_r ##[0:3] full_r;
   endproperty
   a_addr_wake: assert property (p_addr_wake) else $error("address wake wrong");

   property p_ctrl_load;
      @(posedge i_clk) disable iff (!i_rst_n)
      ctrl_wr |=> (mute_r == $past(i_wdata[CT_MUTE]));
   endproperty
   a_ctrl_load: assert property (p_ctrl_load) else $error("mute not loaded");

endmodule : sbr_rx_top
`default_nettype wire

// ==== test/sbr_node.sv ====
// Purpose: Far serial node that puts framed words on the receive line
// Assumes: Line is synchronous to the clock and idles high
// Notes:   A low stop level gives framing or break errors on demand
`timescale 1ns/1ps
`default_nettype none
module sbr_node (
   // Clock
   input  wire logic i_clk,
   // Serial line
   output logic      o_rxd
);
   // Pulled high until the first frame
   initial o_rxd = 1'b1;

   // Start, eight data bits LSB first, stop; div is clocks per tick
   task automatic send(input logic [7:0] b, input logic stop, input int div);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rxd <= f[i];
         repeat (16 * div) @(posedge i_clk);
      end
      o_rxd <= 1'b1;
      // One idle edge so a following frame never reassigns the line in this step
      @(posedge i_clk);
   endtask : send
endmodule : sbr_node
`default_nettype wire

// ==== test/sbr_rx_top_bench.sv ====
// Purpose: Bus and line tests of the serial receive block
// Assumes: Node model drives the line; one bus access at a time
// Notes:   Small rate settings keep a bit within 16 to 96 clocks
`timescale 1ns/1ps
`default_nettype none
module sbr_rx_top_bench;
   import sbr_pkg::*;
   logic i_clk, i_rst_n, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_rxd;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_tick, o_rx_full, o_muted;
   logic [7:0]  i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          per;
   int          pr[4] = '{1, 3, 4, 13};

   sbr_rx_top u_sbr_rx_top (.*);
   sbr_node u_sbr_node (.i_clk(i_clk), .o_rxd(i_rxd));

   // 200 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge i_clk);
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_awaddr  <= a;
      i_wdata   <= {24'h0, d};
      i_bready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, o_bresp});
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
      @(posedge i_clk);
      i_arvalid <= 1'b1;
      i_araddr  <= a;
      i_rready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      chk(nm, e, o_rdata);
      chk("rresp", {30'h0, er}, {30'h0, o_rresp});
   endtask : rdc

   // Rates only change while both directions are off
   task automatic tick_per(input logic [7:0] rate, input logic [7:0] fine, input int e);
      wr(OFF_CTRL2, 8'h00);
      wr(OFF_RATE, rate);
      wr(OFF_FINE_TX, fine);
      wr(OFF_CTRL2, 8'h08);
      do @(posedge i_clk); while (o_tx_tick !== 1'b1);
      per = 0;
      do begin
         @(posedge i_clk);
         per++;
      end while (o_tx_tick !== 1'b1 && per < 2000);
      chk("tick_period", 32'(e), 32'(per));
   endtask : tick_per

   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      i_rst_n   = 1'b0;
      i_ce      = 1'b1;
      i_awvalid = 1'b0;
      i_wvalid  = 1'b0;
      i_bready  = 1'b0;
      i_arvalid = 1'b0;
      i_rready  = 1'b0;
      i_awaddr  = 8'h00;
      i_araddr  = 8'h00;
      i_wdata   = 32'h0;
      i_wstrb   = 4'hf;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int a = 0; a < 24; a += 4) rdc("reset_value", 8'(a), 32'h0);
      rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 8'h00, RESP_SLVERR);
      for (int s = 0; s < 8; s++) tick_per({3'h0, 3'(s), 2'h0}, 8'h00, 1 << s);
      for (int s = 0; s < 4; s++) tick_per({6'h0, 2'(s)}, 8'h00, pr[s]);
      tick_per(8'h01, 8'hff, 765);
      // Enable low for 100 cycles must stretch the period by exactly that much
      do @(posedge i_clk); while (o_tx_tick !== 1'b1);
      i_ce <= 1'b0;
      repeat (100) @(posedge i_clk);
      i_ce <= 1'b1;
      per = 0;
      do begin
         @(posedge i_clk);
         per++;
      end while (o_tx_tick !== 1'b1 && per < 2000);
      chk("ce_freeze", 32'd765, 32'(per));
      wr(OFF_CTRL2, 8'h00);
      wr(OFF_RATE, 8'h20);
      wr(OFF_FINE_RX, 8'h03);
      wr(OFF_CTRL2, 8'h04);
      u_sbr_node.send(8'h5a, 1'b1, 6);
      rdc("status", OFF_STATUS, 32'h20);
      rdc("data", OFF_DATA, 32'h5a);
      wr(OFF_CTRL2, 8'h00);
      wr(OFF_RATE, 8'h00);
      wr(OFF_FINE_RX, 8'h00);
      wr(OFF_CTRL2, 8'h04);
      u_sbr_node.send(8'h3c, 1'b0, 1);
      rdc("status", OFF_STATUS, 32'h22);
      rdc("data", OFF_DATA, 32'h3c);
      u_sbr_node.send(8'h00, 1'b0, 1);
      rdc("data", OFF_DATA, 32'h00);
      rdc("status", OFF_STATUS, 32'h02);
      rdc("data", OFF_DATA, 32'h00);
      rdc("status", OFF_STATUS, 32'h00);
      wr(OFF_CTRL2, 8'h07);
      chk("muted", 32'h1, 32'(o_muted));
      u_sbr_node.send(8'h12, 1'b1, 1);
      chk("muted_full", 32'h0, 32'(o_rx_full));
      u_sbr_node.send(8'h81, 1'b1, 1);
      chk("mark_wake", 32'h0, 32'(o_muted));
      rdc("status", OFF_STATUS, 32'h20);
      rdc("data", OFF_DATA, 32'h81);
      repeat (200) @(posedge i_clk);
      rdc("status", OFF_STATUS, 32'h10);
      rdc("data", OFF_DATA, 32'h81);
      wr(OFF_CTRL2, 8'h05);
      u_sbr_node.send(8'h12, 1'b1, 1);
      chk("muted_full", 32'h0, 32'(o_rx_full));
      chk("still_muted", 32'h1, 32'(o_muted));
      repeat (200) @(posedge i_clk);
      chk("idle_wake", 32'h0, 32'(o_muted));
      rdc("status", OFF_STATUS, 32'h00);
      wr(OFF_CTRL2, 8'h05);
      chk("remuted", 32'h1, 32'(o_muted));
      end_of_test();
   end

   // Hang guard, well beyond the expected run
   initial begin
      #200us;
      n_mismatch++;
      end_of_test();
   end
endmodule : sbr_rx_top_bench
`default_nettype wire
